// ==== cec_pkg.sv ====
`default_nettype none
package cec_pkg;
    localparam logic [22:0] RESET_PC      = 23'h000000;
    localparam logic [3:0]  SP_IDX        = 4'hF;
    localparam logic [15:0] WORD_STEP     = 16'h0002;
    localparam logic [15:0] DMA_BASE      = 16'h1000;
    localparam logic [15:0] DMA_LAST      = 16'h17FF;
    localparam logic [4:0]  SHIFT_MAX     = 5'h10;
    localparam logic [4:0]  DIV_ITER_LAST = 5'h10;
    localparam logic [13:0] DIV_REPEAT    = 14'h0011;
    localparam int          OP_LSB        = 20;
    localparam int          WD_LSB        = 16;
    localparam int          WS_LSB        = 12;
    localparam int          WB_LSB        = 8;
    localparam int          SAVE_REP_BIT  = 15;
    localparam int          SAVE_IEN_BIT  = 14;
    localparam logic [3:0]  OP_NOP        = 4'h0;
    localparam logic [3:0]  OP_ADD        = 4'h1;
    localparam logic [3:0]  OP_SUB        = 4'h2;
    localparam logic [3:0]  OP_LOAD       = 4'h3;
    localparam logic [3:0]  OP_STORE      = 4'h4;
    localparam logic [3:0]  OP_MOVL       = 4'h5;
    localparam logic [3:0]  OP_MUL        = 4'h6;
    localparam logic [3:0]  OP_SHIFT      = 4'h7;
    localparam logic [3:0]  OP_REPEAT     = 4'h8;
    localparam logic [3:0]  OP_DIV        = 4'h9;
    localparam logic [3:0]  OP_GOTO       = 4'hA;
    localparam logic [3:0]  OP_CALL       = 4'hB;
    localparam logic [3:0]  OP_BRZ        = 4'hC;
    localparam logic [3:0]  OP_ADDM       = 4'hD;
    localparam logic [3:0]  OP_EXT        = 4'hF;
    localparam logic [3:0]  EXT_RET       = 4'h0;
    localparam logic [3:0]  EXT_MOVD      = 4'h1;
    localparam logic [3:0]  EXT_PAGE      = 4'h2;
    localparam logic [3:0]  EXT_IRQEN     = 4'h3;

    typedef enum logic [3:0] {
        ST_EXEC    = 4'b0001,
        ST_PUSH_HI = 4'b0010,
        ST_POP_LO  = 4'b0100,
        ST_MOVD_HI = 4'b1000
    } cec_state_t;

    typedef struct packed {
        logic [15:0] raddr;
        logic        re;
        logic [15:0] waddr;
        logic [15:0] wdata;
        logic        we;
    } cec_dreq_t;

    typedef struct packed {
        cec_state_t       st;
        logic [22:0]      pc;
        logic [23:0]      ir;
        logic             irValid;
        logic [15:0][15:0] w;
        logic             repActive;
        logic [13:0]      repCount;
        logic             irqEn;
        logic             psvEn;
        logic [7:0]       page;
        logic [4:0]       divStep;
        logic [16:0]      divRem;
        logic [15:0]      divQuo;
        logic [22:0]      tmpPc;
        logic [15:0]      tmpHi;
        logic [3:0]       tmpIdx;
    } cec_core_t;

    localparam cec_core_t CORE_RESET = '{st: ST_EXEC, pc: RESET_PC, default: '0};
endpackage
`default_nettype wire

// ==== cec_core.sv ====
`default_nettype none
module cec_core
    import cec_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        master_clear_n,
    output logic [22:0]      progAddr,
    input  wire logic [23:0] progRdData,
    output logic [22:0]      winAddr,
    output logic             winRdEn,
    input  wire logic [23:0] winRdData,
    output cec_dreq_t        dataReq,
    input  wire logic [15:0] dataRdData,
    output logic             dataInDma,
    input  wire logic        irqReq,
    input  wire logic [22:0] irqVector,
    output logic             irqAck
);

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    function automatic logic [31:0] cec_mul(input logic [15:0] a, input logic [15:0] b,
                                            input logic sa, input logic sb);
        logic signed [16:0] ax;
        logic signed [16:0] bx;
        logic signed [33:0] p;
        // Extra top bit makes mixed-sign products exact
        ax = {sa & a[15], a};
        bx = {sb & b[15], b};
        p  = ax * bx;
        return p[31:0];
    endfunction

    function automatic logic [15:0] cec_shift(input logic [15:0] v, input logic [15:0] amt,
                                              input logic right, input logic arith);
        logic [4:0]  n;
        logic [31:0] x;
        n = (amt > {11'h000, SHIFT_MAX}) ? SHIFT_MAX : amt[4:0];
        if (right) begin
            x = {{16{arith & v[15]}}, v} >> n;
        end else begin
            x = {16'h0000, v} << n;
        end
        return x[15:0];
    endfunction

    function automatic logic cec_in_dma(input logic [15:0] addr);
        return (addr >= DMA_BASE) && (addr <= DMA_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    cec_core_t   coreReg;
    cec_core_t   coreNext;
    logic [23:0] ins;
    logic [3:0]  op;
    logic [3:0]  wd;
    logic [3:0]  ws;
    logic [3:0]  wb;
    logic [15:0] ea;
    logic [15:0] sp;
    logic [22:0] retPc;
    logic [15:0] rdAddr;
    logic        rdWinHit;
    logic [15:0] rdWord;
    logic [16:0] divSh;
    logic [15:0] divQ;

    assign ins      = coreReg.ir;
    assign op       = ins[OP_LSB+:4];
    assign wd       = ins[WD_LSB+:4];
    assign ws       = ins[WS_LSB+:4];
    assign wb       = ins[WB_LSB+:4];
    assign ea       = coreReg.w[ws] + {{8{ins[7]}}, ins[7:0]};
    assign sp       = coreReg.w[SP_IDX];
    assign retPc    = coreReg.pc - 23'h000001;
    assign progAddr = coreReg.pc;

    always_comb begin
        rdAddr = ea;
        if (coreReg.st == ST_POP_LO ||
            (coreReg.st == ST_EXEC && op == OP_EXT && wd == EXT_RET)) begin
            rdAddr = sp - WORD_STEP;
        end else if (coreReg.st == ST_MOVD_HI) begin
            rdAddr = coreReg.tmpHi;
        end else if (coreReg.st == ST_EXEC && op == OP_EXT && wd == EXT_MOVD) begin
            rdAddr = coreReg.w[ws];
        end
    end

    // Window reads use a second program port so fetch never stalls
    assign rdWinHit = coreReg.psvEn && rdAddr[15];
    assign winAddr  = {1'b0, coreReg.page, rdAddr[14:1]};
    assign rdWord   = rdWinHit ? winRdData[15:0] : dataRdData;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        coreNext      = coreReg;
        dataReq       = '0;
        dataReq.raddr = rdAddr;
        irqAck        = 1'b0;
        winRdEn       = 1'b0;
        divSh         = 17'h00000;
        divQ          = 16'h0000;
        case (coreReg.st)
            ST_EXEC: begin
                if (!coreReg.irValid) begin
                    // Refill after a flow change
                    coreNext.pc      = coreReg.pc + 23'h000001;
                    coreNext.ir      = progRdData;
                    coreNext.irValid = 1'b1;
                end else if (irqReq && coreReg.irqEn) begin
                    // Taken in place of the held instruction, even mid-repeat
                    dataReq.waddr      = sp;
                    dataReq.wdata      = retPc[15:0];
                    dataReq.we         = 1'b1;
                    coreNext.w[SP_IDX] = sp + WORD_STEP;
                    coreNext.tmpHi     = {coreReg.repActive, coreReg.irqEn, 7'h00, retPc[22:16]};
                    coreNext.tmpPc     = irqVector;
                    coreNext.repActive = 1'b0;
                    coreNext.irqEn     = 1'b0;
                    coreNext.irValid   = 1'b0;
                    coreNext.st        = ST_PUSH_HI;
                    irqAck             = 1'b1;
                end else begin
                    coreNext.pc = coreReg.pc + 23'h000001;
                    coreNext.ir = progRdData;
                    if (coreReg.repActive) begin
                        if (coreReg.repCount != 14'h0000) begin
                            coreNext.repCount = coreReg.repCount - 14'h0001;
                            coreNext.pc       = coreReg.pc;
                            coreNext.ir       = coreReg.ir;
                        end else begin
                            coreNext.repActive = 1'b0;
                        end
                    end
                    case (op)
                        OP_ADD: begin
                            coreNext.w[wd] = coreReg.w[ws] + coreReg.w[wb];
                        end
                        OP_SUB: begin
                            coreNext.w[wd] = coreReg.w[ws] - coreReg.w[wb];
                        end
                        OP_LOAD: begin
                            dataReq.re     = 1'b1;
                            coreNext.w[wd] = rdWord;
                        end
                        OP_STORE: begin
                            dataReq.waddr = ea;
                            dataReq.wdata = coreReg.w[wb];
                            dataReq.we    = 1'b1;
                        end
                        OP_ADDM: begin
                            dataReq.re    = 1'b1;
                            dataReq.waddr = coreReg.w[wd];
                            dataReq.wdata = rdWord + coreReg.w[wb];
                            dataReq.we    = 1'b1;
                        end
                        OP_MOVL: begin
                            coreNext.w[wd] = ins[15:0];
                        end
                        OP_MUL: begin
                            {coreNext.w[wd + 4'h1], coreNext.w[wd]} =
                                cec_mul(coreReg.w[ws], coreReg.w[wb], ins[1], ins[0]);
                        end
                        OP_SHIFT: begin
                            coreNext.w[wd] = cec_shift(coreReg.w[ws], coreReg.w[wb], ins[0], ins[1]);
                        end
                        OP_REPEAT: begin
                            coreNext.repActive = 1'b1;
                            coreNext.repCount  = ins[13:0];
                        end
                        OP_DIV: begin
                            // Partial state lives in dedicated registers that survive an interrupt
                            if (coreReg.divStep == 5'h00) begin
                                coreNext.divRem  = {1'b0, ins[0] ? coreReg.w[ws + 4'h1] : 16'h0000};
                                coreNext.divQuo  = coreReg.w[ws];
                                coreNext.divStep = 5'h01;
                            end else if (coreReg.divStep <= DIV_ITER_LAST) begin
                                divSh = {coreReg.divRem[15:0], coreReg.divQuo[15]};
                                divQ  = {coreReg.divQuo[14:0], 1'b0};
                                if (divSh >= {1'b0, coreReg.w[wb]}) begin
                                    divSh   = divSh - {1'b0, coreReg.w[wb]};
                                    divQ[0] = 1'b1;
                                end
                                coreNext.divRem  = divSh;
                                coreNext.divQuo  = divQ;
                                coreNext.divStep = coreReg.divStep + 5'h01;
                            end else begin
                                coreNext.w[0]    = coreReg.divQuo;
                                coreNext.w[1]    = coreReg.divRem[15:0];
                                coreNext.divStep = 5'h00;
                            end
                        end
                        OP_GOTO: begin
                            coreNext.pc      = {3'h0, ins[19:0]};
                            coreNext.irValid = 1'b0;
                        end
                        OP_CALL: begin
                            dataReq.waddr      = sp;
                            dataReq.wdata      = coreReg.pc[15:0];
                            dataReq.we         = 1'b1;
                            coreNext.w[SP_IDX] = sp + WORD_STEP;
                            coreNext.tmpHi     = {1'b0, coreReg.irqEn, 7'h00, coreReg.pc[22:16]};
                            coreNext.tmpPc     = {3'h0, ins[19:0]};
                            coreNext.irValid   = 1'b0;
                            coreNext.st        = ST_PUSH_HI;
                        end
                        OP_BRZ: begin
                            if (coreReg.w[wd] == 16'h0000) begin
                                coreNext.pc      = retPc + {{7{ins[15]}}, ins[15:0]};
                                coreNext.irValid = 1'b0;
                            end
                        end
                        OP_EXT: begin
                            // Long opcode: the destination field selects the operation
                            case (wd)
                                EXT_RET: begin
                                    dataReq.re         = 1'b1;
                                    coreNext.tmpHi     = rdWord;
                                    coreNext.w[SP_IDX] = sp - WORD_STEP;
                                    coreNext.irValid   = 1'b0;
                                    coreNext.st        = ST_POP_LO;
                                end
                                EXT_MOVD: begin
                                    dataReq.re      = 1'b1;
                                    coreNext.w[wb]  = rdWord;
                                    coreNext.tmpHi  = coreReg.w[ws] + WORD_STEP;
                                    coreNext.tmpIdx = wb + 4'h1;
                                    coreNext.st     = ST_MOVD_HI;
                                end
                                EXT_PAGE: begin
                                    coreNext.psvEn = ins[8];
                                    coreNext.page  = ins[7:0];
                                end
                                EXT_IRQEN: begin
                                    coreNext.irqEn = ins[0];
                                end
                                default: begin
                                end
                            endcase
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_PUSH_HI: begin
                dataReq.waddr      = sp;
                dataReq.wdata      = coreReg.tmpHi;
                dataReq.we         = 1'b1;
                coreNext.w[SP_IDX] = sp + WORD_STEP;
                coreNext.pc        = coreReg.tmpPc;
                coreNext.irValid   = 1'b0;
                coreNext.st        = ST_EXEC;
            end
            ST_POP_LO: begin
                dataReq.re         = 1'b1;
                coreNext.w[SP_IDX] = sp - WORD_STEP;
                coreNext.pc        = {coreReg.tmpHi[6:0], rdWord};
                coreNext.repActive = coreReg.tmpHi[SAVE_REP_BIT];
                coreNext.irqEn     = coreReg.tmpHi[SAVE_IEN_BIT];
                coreNext.irValid   = 1'b0;
                coreNext.st        = ST_EXEC;
            end
            ST_MOVD_HI: begin
                // Fetch bus idle here; the next instruction is already held
                dataReq.re              = 1'b1;
                coreNext.w[coreReg.tmpIdx] = rdWord;
                coreNext.st             = ST_EXEC;
            end
            default: begin
                coreNext = CORE_RESET;
            end
        endcase
        winRdEn    = dataReq.re & rdWinHit;
        dataReq.re = dataReq.re & ~rdWinHit;
        if (!master_clear_n) begin
            coreNext = CORE_RESET;
            dataReq  = '0;
            irqAck   = 1'b0;
            winRdEn  = 1'b0;
        end
    end

    assign dataInDma = (dataReq.re && cec_in_dma(dataReq.raddr)) ||
                       (dataReq.we && cec_in_dma(dataReq.waddr));

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            coreReg <= CORE_RESET;
        end else begin
            coreReg <= coreNext;
        end
    end

endmodule
`default_nettype wire

// ==== cec_core_assertions.sv ====
`default_nettype none
module cec_core_assertions
    import cec_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        master_clear_n,
    input wire logic [22:0] progAddr,
    input wire logic [22:0] winAddr,
    input wire logic        winRdEn,
    input wire cec_dreq_t   dataReq,
    input wire logic        dataInDma,
    input wire logic        irqReq,
    input wire logic [22:0] irqVector,
    input wire logic        irqAck
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    a_clear_quiet: assert property (!master_clear_n |-> !dataReq.re && !dataReq.we && !winRdEn && !irqAck)
        else $error("request active during master clear");
    a_clear_pc: assert property (!master_clear_n |=> progAddr == RESET_PC)
        else $error("fetch address not at reset vector");
    a_irq_cause: assert property (irqAck |-> irqReq && master_clear_n)
        else $error("interrupt taken without request");
    a_irq_single: assert property (irqAck |=> !irqAck)
        else $error("interrupt acknowledge longer than one cycle");
    // Entry pushes two words upward through the stack pointer
    a_irq_push: assert property (
        irqAck |-> dataReq.we ##1 (dataReq.we && dataReq.waddr == $past(dataReq.waddr) + WORD_STEP))
        else $error("interrupt entry stack push wrong");
    a_irq_target: assert property (irqAck |-> ##2 progAddr == $past(irqVector, 2))
        else $error("interrupt target not fetched");
    a_window_read: assert property (
        winRdEn |-> !dataReq.re && dataReq.raddr[15] && !winAddr[22] && winAddr[13:0] == dataReq.raddr[14:1])
        else $error("program window address wrong");
    a_dma_flag: assert property (
        1'b1 |-> dataInDma == ((dataReq.re && dataReq.raddr inside {[DMA_BASE:DMA_LAST]}) ||
                               (dataReq.we && dataReq.waddr inside {[DMA_BASE:DMA_LAST]})))
        else $error("dma region flag wrong");
endmodule
bind cec_core cec_core_assertions i_cec_core_assertions (
    .ref_clk(ref_clk), .rst(rst), .master_clear_n(master_clear_n), .progAddr(progAddr), .winAddr(winAddr),
    .winRdEn(winRdEn), .dataReq(dataReq), .dataInDma(dataInDma), .irqReq(irqReq), .irqVector(irqVector),
    .irqAck(irqAck)
);
`default_nettype wire

// ==== cec_mem_model.sv ====
`default_nettype none
module cec_mem_model
    import cec_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [22:0] progAddr,
    output logic [23:0]      progRdData,
    input  wire logic [22:0] winAddr,
    input  wire logic        winRdEn,
    output logic [23:0]      winRdData,
    input  wire cec_dreq_t   dataReq,
    output logic [15:0]      dataRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] prog [0:127];
    logic [15:0] dmem [0:4095];
    logic [15:0] noise = 16'hA5C3;
    ////////////////////////////////////////////////////////////////////////
    // Idle lines wander each cycle so a stale sample cannot pass
    always @(posedge ref_clk) begin
        noise <= ~{noise[14:0], noise[15]};
        if (dataReq.we) begin
            dmem[dataReq.waddr[12:1]] <= dataReq.wdata;
        end
    end
    // Only 128 program words exist; beyond them fetch sees noise
    assign progRdData = (progAddr < 23'h000080) ? prog[progAddr[6:0]] : {8'h00, noise};
    assign dataRdData = dataReq.re ? dmem[dataReq.raddr[12:1]] : noise;
    assign winRdData  = winRdEn ? {8'h00, winAddr[15:0] ^ 16'h5A5A} : {noise, 8'h00};
endmodule
`default_nettype wire

// ==== cpu_execution_core_test.sv ====
`default_nettype none
module cpu_execution_core_test
    import cec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0]  op;
        logic [7:0]  ctl;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] lo;
        logic [15:0] hi;
    } cec_row_t;
    localparam int       LIMIT = 2000;
    localparam cec_row_t ROWS [12] = '{
        '{OP_ADD, 8'h00, 16'hFFFF, 16'h0002, 16'h0001, 16'h0000},
        '{OP_SUB, 8'h00, 16'h0003, 16'h0005, 16'hFFFE, 16'h0000},
        '{OP_MUL, 8'h00, 16'hFFFF, 16'h0002, 16'hFFFE, 16'h0001},
        '{OP_MUL, 8'h01, 16'hFFFF, 16'h0002, 16'hFFFE, 16'h0001},
        '{OP_MUL, 8'h02, 16'hFFFF, 16'h0002, 16'hFFFE, 16'hFFFF},
        '{OP_MUL, 8'h03, 16'hFFFF, 16'h0002, 16'hFFFE, 16'hFFFF},
        '{OP_SHIFT, 8'h00, 16'h8001, 16'h0004, 16'h0010, 16'h0000},
        '{OP_SHIFT, 8'h01, 16'h8001, 16'h0004, 16'h0800, 16'h0000},
        '{OP_SHIFT, 8'h03, 16'h8001, 16'h0004, 16'hF800, 16'h0000},
        '{OP_SHIFT, 8'h00, 16'h8001, 16'h0010, 16'h0000, 16'h0000},
        '{OP_SHIFT, 8'h03, 16'h8001, 16'h0014, 16'hFFFF, 16'h0000},
        '{OP_SHIFT, 8'h01, 16'h8001, 16'h000F, 16'h0001, 16'h0000}};
    logic        ref_clk;
    logic        rst;
    logic        master_clear_n;
    logic        irqReq;
    logic [22:0] irqVector;
    logic [22:0] progAddr;
    logic [23:0] progRdData;
    logic [22:0] winAddr;
    logic        winRdEn;
    logic [23:0] winRdData;
    cec_dreq_t   dataReq;
    logic [15:0] dataRdData;
    logic        dataInDma;
    logic        irqAck;
    logic [23:0] big [20];
    logic [23:0] flow [12];
    int          errors;
    int          checks_done;
    int          cycles;
    int          acks;
    int          dmaHits;
    ////////////////////////////////////////////////////////////////////////
    cec_core i_cec_core (.ref_clk(ref_clk), .rst(rst), .master_clear_n(master_clear_n), .progAddr(progAddr),
        .progRdData(progRdData), .winAddr(winAddr), .winRdEn(winRdEn), .winRdData(winRdData), .dataReq(dataReq),
        .dataRdData(dataRdData), .dataInDma(dataInDma), .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck));
    cec_mem_model i_cec_mem_model (.ref_clk(ref_clk), .progAddr(progAddr), .progRdData(progRdData),
        .winAddr(winAddr), .winRdEn(winRdEn), .winRdData(winRdData), .dataReq(dataReq), .dataRdData(dataRdData));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] mk(input logic [3:0] op, wd, ws, wb, input logic [7:0] lit);
        return {op, wd, ws, wb, lit};
    endfunction
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Master clear low while the program is swapped underneath
    task automatic clear_core();
        @(posedge ref_clk);
        #1 master_clear_n = 1'b0;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            complete_run();
        end
    end
    // Sampled mid-cycle, away from the edge that consumes it
    always @(negedge ref_clk) if (irqAck === 1'b1) acks++;
    always @(negedge ref_clk) if (dataInDma === 1'b1) dmaHits++;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        master_clear_n = 1'b1;
        irqReq = 1'b0;
        irqVector = 23'h000040;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        acks = 0;
        dmaHits = 0;
        for (int i = 0; i < 128; i++) i_cec_mem_model.prog[i] = 24'h000000;
        for (int i = 0; i < 4096; i++) i_cec_mem_model.dmem[i] = 16'h0000;
        repeat (16) @(posedge ref_clk);
        check16("fetch address in reset", 16'h0000, progAddr[15:0]);
        #1 rst = 1'b0;
        foreach (ROWS[r]) begin
            clear_core();
            i_cec_mem_model.prog[0] = {OP_MOVL, 4'h1, ROWS[r].a};
            i_cec_mem_model.prog[1] = {OP_MOVL, 4'h2, ROWS[r].b};
            i_cec_mem_model.prog[2] = mk(ROWS[r].op, 4'h3, 4'h1, 4'h2, ROWS[r].ctl);
            i_cec_mem_model.prog[3] = mk(OP_STORE, 4'h0, 4'h0, 4'h3, 8'h04);
            i_cec_mem_model.prog[4] = mk(OP_STORE, 4'h0, 4'h0, 4'h4, 8'h06);
            i_cec_mem_model.prog[5] = {OP_GOTO, 20'h00005};
            i_cec_mem_model.dmem[2] = 16'hDEAD;
            i_cec_mem_model.dmem[3] = 16'hDEAD;
            @(posedge ref_clk);
            #1 master_clear_n = 1'b1;
            repeat (14) @(posedge ref_clk);
            check16("result low", ROWS[r].lo, i_cec_mem_model.dmem[2]);
            check16("result high", ROWS[r].hi, i_cec_mem_model.dmem[3]);
        end
        // Pass 1 interrupts the divide; pass 0 asks while interrupts are off
        for (int k = 0; k < 2; k++) begin
            clear_core();
            big = '{{OP_MOVL, 4'hF, 16'h0100}, mk(OP_EXT, EXT_IRQEN, 4'h0, 4'h0, 8'(k)),
                mk(OP_EXT, EXT_PAGE, 4'h0, 4'h1, 8'h03), {OP_MOVL, 4'h7, 16'h0020}, {OP_MOVL, 4'hB, 16'h8010},
                {OP_MOVL, 4'hC, 16'h1000}, {OP_MOVL, 4'h2, 16'h0005}, {OP_MOVL, 4'h3, 16'(k)},
                {OP_MOVL, 4'h4, 16'h0010}, mk(OP_ADDM, 4'h5, 4'h5, 4'h4, 8'h20),
                mk(OP_EXT, EXT_MOVD, 4'h7, 4'h8, 8'h00), mk(OP_LOAD, 4'hA, 4'hB, 4'h0, 8'h00),
                {OP_REPEAT, 6'h00, DIV_REPEAT}, mk(OP_DIV, 4'h0, 4'h2, 4'h4, 8'(k)),
                mk(OP_STORE, 4'h0, 4'h5, 4'h0, 8'h02), mk(OP_STORE, 4'h0, 4'h5, 4'h1, 8'h04),
                mk(OP_STORE, 4'h0, 4'h5, 4'h9, 8'h06), mk(OP_STORE, 4'h0, 4'h5, 4'hA, 8'h08),
                mk(OP_STORE, 4'h0, 4'hC, 4'h8, 8'h00), {OP_GOTO, 20'h00013}};
            foreach (big[i]) i_cec_mem_model.prog[i] = big[i];
            i_cec_mem_model.prog[64] = mk(OP_EXT, EXT_RET, 4'h0, 4'h0, 8'h00);
            for (int i = 0; i < 5; i++) i_cec_mem_model.dmem[i] = 16'hDEAD;
            i_cec_mem_model.dmem[12'h800] = 16'hDEAD;
            i_cec_mem_model.dmem[16] = 16'h1234;
            i_cec_mem_model.dmem[17] = 16'hBEEF;
            @(posedge ref_clk);
            #1 master_clear_n = 1'b1;
            repeat (20) @(posedge ref_clk);
            #1 irqReq = 1'b1;
            for (int n = 0; n < 12; n++) begin
                @(negedge ref_clk);
                if (irqAck === 1'b1) break;
            end
            @(posedge ref_clk);
            #1 irqReq = 1'b0;
            repeat (60) @(posedge ref_clk);
            check16("interrupts taken", 16'(k), 16'(acks));
            check16("sum in memory", 16'h1244, i_cec_mem_model.dmem[0]);
            check16("quotient", k ? 16'h1000 : 16'h0000, i_cec_mem_model.dmem[1]);
            check16("remainder", 16'h0005, i_cec_mem_model.dmem[2]);
            check16("double move", 16'hBEEF, i_cec_mem_model.dmem[3]);
            check16("window read", 16'hC008 ^ 16'h5A5A, i_cec_mem_model.dmem[4]);
            check16("dma write", 16'h1234, i_cec_mem_model.dmem[12'h800]);
            check16("dma flag cycles", 16'(k + 1), 16'(dmaHits));
            if (k == 1) check16("saved state", 16'hC000, i_cec_mem_model.dmem[8'h81]);
        end
        // Taken branch skips two words; call and return bring the stack pointer back
        clear_core();
        flow = '{{OP_MOVL, 4'hF, 16'h0100}, {OP_BRZ, 4'h6, 16'h0003}, {OP_MOVL, 4'h1, 16'hBAD0},
            {OP_MOVL, 4'h1, 16'hBAD1}, {OP_CALL, 20'h0000A}, mk(OP_LOAD, 4'h3, 4'h0, 4'h0, 8'h0A),
            mk(OP_STORE, 4'h0, 4'h0, 4'h3, 8'h02), mk(OP_STORE, 4'h0, 4'h0, 4'h1, 8'h00),
            mk(OP_STORE, 4'h0, 4'h0, 4'hF, 8'h04), {OP_GOTO, 20'h00009}, {OP_MOVL, 4'h1, 16'hC5C5},
            mk(OP_EXT, EXT_RET, 4'h0, 4'h0, 8'h00)};
        foreach (flow[i]) i_cec_mem_model.prog[i] = flow[i];
        i_cec_mem_model.dmem[5] = 16'h5A11;
        i_cec_mem_model.dmem[8'h80] = 16'hDEAD;
        @(posedge ref_clk);
        #1 master_clear_n = 1'b1;
        repeat (30) @(posedge ref_clk);
        check16("branch and call", 16'hC5C5, i_cec_mem_model.dmem[0]);
        check16("plain load", 16'h5A11, i_cec_mem_model.dmem[1]);
        check16("stack restored", 16'h0100, i_cec_mem_model.dmem[2]);
        check16("return address", 16'h0005, i_cec_mem_model.dmem[8'h80]);
        check16("dma flag total", 16'h0002, 16'(dmaHits));
        complete_run();
    end
endmodule
`default_nettype wire
